/* nmp_pkg.sv */
// nmp_pkg: shared constants and types of the memory protection fuse block.
// assumes a 32-bit apb register bus and 22-bit program memory addresses.
package nmp_pkg;

    // register indices; byte address on apb is four times the index
    localparam logic [23:0] NMP_IDX_CODE_PROTECT_HIGH = 24'h300009;
    localparam logic [23:0] NMP_IDX_WRITE_PROTECT_LOW = 24'h30000A;
    localparam logic [23:0] NMP_IDX_WRITE_PROTECT_HIGH = 24'h30000B;
    localparam logic [23:0] NMP_IDX_TABLE_READ_PROTECT_LOW = 24'h30000C;
    localparam logic [23:0] NMP_IDX_ERASE_CTRL = 24'h300010;
    localparam logic [23:0] NMP_IDX_STATUS = 24'h300011;
    localparam logic [5:0] NMP_ADDR_TOP_ZERO = 6'h00;

    // implemented bit masks of the four fuse bytes
    localparam logic [7:0] NMP_IMPL_CPH = 8'hC0;
    localparam logic [7:0] NMP_IMPL_WPL = 8'h0F;
    localparam logic [7:0] NMP_IMPL_WPH = 8'hE0;
    localparam logic [7:0] NMP_IMPL_TRL = 8'h0F;
    localparam logic [7:0] NMP_FUSE_ERASED = 8'hFF;
    localparam logic [7:0] NMP_BLK3_MASK = 8'h08;
    localparam logic [7:0] NMP_ZERO_BYTE = 8'h00;

    // field positions
    localparam int NMP_BIT_EEPROM_CODE = 7;
    localparam int NMP_BIT_BOOT_CODE = 6;
    localparam int NMP_BIT_EEPROM_WRITE = 7;
    localparam int NMP_BIT_BOOT_WRITE = 6;
    localparam int NMP_BIT_CFG_WRITE = 5;
    localparam int NMP_BIT_ERASE_GO = 0;
    localparam int NMP_BIT_DENY_STICKY = 1;

    // address map of guarded regions
    localparam logic [21:0] NMP_BOOT_END = 22'h0007FF;
    localparam logic [21:0] NMP_BLK_END = 22'h00FFFF;
    localparam logic [21:0] NMP_CFG_BASE = 22'h300000;
    localparam logic [21:0] NMP_CFG_END = 22'h3000FF;

    typedef enum logic [2:0] {
        RGN_BOOT = 3'h0,
        RGN_BLK0 = 3'h1,
        RGN_BLK1 = 3'h2,
        RGN_BLK2 = 3'h3,
        RGN_BLK3 = 3'h4,
        RGN_CFG = 3'h5,
        RGN_OTHER = 3'h6
    } nmp_region_e;

    // access kinds presented by the core or the programmer
    typedef enum logic [2:0] {
        KIND_TBLRD = 3'h0,
        KIND_WRITE = 3'h1,
        KIND_EE_WRITE = 3'h2,
        KIND_EE_EXTREAD = 3'h3,
        KIND_EXT_READ = 3'h4
    } nmp_kind_e;

endpackage

/* nmp_region_decode.sv */
// nmp_region_decode: maps a program address onto its guarded region.
// assumes a 22-bit table pointer address; purely combinational.
`timescale 1ns/100ps
module nmp_region_decode (
    input wire logic [21:0] addr,
    output nmp_pkg::nmp_region_e region
);
    import nmp_pkg::*;

    // boot block is carved out of the bottom of block 0
    always_comb begin
        if (addr <= NMP_BOOT_END) begin
            region = RGN_BOOT;
        end else if (addr <= NMP_BLK_END) begin
            case (addr[15:14])
                2'h0: region = RGN_BLK0;
                2'h1: region = RGN_BLK1;
                2'h2: region = RGN_BLK2;
                default: region = RGN_BLK3;
            endcase
        end else if (addr >= NMP_CFG_BASE && addr <= NMP_CFG_END) begin
            region = RGN_CFG;
        end else begin
            region = RGN_OTHER;
        end
    end
endmodule

/* nmp_fuse_byte.sv */
// nmp_fuse_byte: one clear-only fuse byte with erase back to all ones.
// assumes clear and erase strobes are one-cycle pulses on core_clk.
`timescale 1ns/100ps
module nmp_fuse_byte #(
    parameter logic [7:0] IMPL = 8'hFF
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clearEn,
    input wire logic [7:0] clearData,
    input wire logic eraseEn,
    input wire logic [7:0] forceMask,
    output logic [7:0] value
);
    import nmp_pkg::*;

    logic [7:0] fuse_reg;

    // programming only moves a bit 1 to 0; only erase or reset brings it back
    always_ff @(posedge core_clk) begin
        if (reset || eraseEn) begin
            fuse_reg <= NMP_FUSE_ERASED;
        end else if (clearEn) begin
            fuse_reg <= fuse_reg & (clearData | ~IMPL);
        end
    end

    // forced bits stay set on parts where they do not exist
    assign value = (fuse_reg | forceMask) & IMPL;
endmodule

/* nmp_protect_top.sv */
// nmp_protect_top: protection fuses for boot block, program blocks,
// data eeprom and configuration space, with access checking.
// assumes an apb master on core_clk and a core that waits for rspValid.
//
// Design decision made here: register access over APB.
`timescale 1ns/100ps
module nmp_protect_top (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic smallPart,
    input wire logic reqValid,
    input wire nmp_pkg::nmp_kind_e reqKind,
    input wire logic [21:0] reqAddr,
    input wire logic [21:0] reqPcAddr,
    output logic rspValid,
    output logic rspAllow,
    output logic memWriteEn,
    output logic eepromCodeGuarded,
    output logic bootCodeGuarded
);
    import nmp_pkg::*;

    logic smallMeta_reg;
    logic smallSync_reg;
    logic denied_reg;
    logic [7:0] cph;
    logic [7:0] wpl;
    logic [7:0] wph;
    logic [7:0] trl;
    logic [7:0] blk3Force;
    logic [23:0] idx;
    logic idxOk;
    logic mapped;
    logic setup;
    logic access;
    logic apbWr;
    logic cfgWr;
    logic eraseCmd;
    logic denyClear;
    logic [7:0] rdByte;
    nmp_region_e tgtRgn;
    nmp_region_e srcRgn;
    logic allowNext;
    logic isWrite;

    // strap pin crosses in from outside; only the second stage is used
    always_ff @(posedge core_clk) begin
        if (reset) begin
            smallMeta_reg <= 1'b0;
            smallSync_reg <= 1'b0;
        end else begin
            smallMeta_reg <= smallPart;
            smallSync_reg <= smallMeta_reg;
        end
    end

    // block 3 guards do not exist on the small part; held at one
    assign blk3Force = smallSync_reg ? NMP_BLK3_MASK : NMP_ZERO_BYTE;

    // apb decode; the top address bits must be zero for a hit
    assign idx = paddr[25:2];
    assign idxOk = (paddr[31:26] == NMP_ADDR_TOP_ZERO) && (paddr[1:0] == 2'h0);
    assign mapped = idxOk && ((idx == NMP_IDX_CODE_PROTECT_HIGH)
        || (idx == NMP_IDX_WRITE_PROTECT_LOW) || (idx == NMP_IDX_WRITE_PROTECT_HIGH)
        || (idx == NMP_IDX_TABLE_READ_PROTECT_LOW) || (idx == NMP_IDX_ERASE_CTRL)
        || (idx == NMP_IDX_STATUS));
    assign setup = psel && !penable;
    assign access = psel && penable && pready;
    assign apbWr = access && pwrite && mapped;

    // fuse programming is refused while config writes are guarded
    assign cfgWr = apbWr && wph[NMP_BIT_CFG_WRITE];
    // erase ignores every guard, as a full device erase must
    assign eraseCmd = apbWr && (idx == NMP_IDX_ERASE_CTRL) && pwdata[NMP_BIT_ERASE_GO];
    assign denyClear = apbWr && (idx == NMP_IDX_STATUS) && pwdata[NMP_BIT_DENY_STICKY];

    // the four fuse bytes; each clears only on its own index
    nmp_fuse_byte #(.IMPL(NMP_IMPL_CPH)) u_cph (
        .core_clk(core_clk),
        .reset(reset),
        .clearEn(cfgWr && (idx == NMP_IDX_CODE_PROTECT_HIGH)),
        .clearData(pwdata[7:0]),
        .eraseEn(eraseCmd),
        .forceMask(NMP_ZERO_BYTE),
        .value(cph)
    );

    nmp_fuse_byte #(.IMPL(NMP_IMPL_WPL)) u_wpl (
        .core_clk(core_clk),
        .reset(reset),
        .clearEn(cfgWr && (idx == NMP_IDX_WRITE_PROTECT_LOW)),
        .clearData(pwdata[7:0]),
        .eraseEn(eraseCmd),
        .forceMask(blk3Force),
        .value(wpl)
    );

    nmp_fuse_byte #(.IMPL(NMP_IMPL_WPH)) u_wph (
        .core_clk(core_clk),
        .reset(reset),
        .clearEn(cfgWr && (idx == NMP_IDX_WRITE_PROTECT_HIGH)),
        .clearData(pwdata[7:0]),
        .eraseEn(eraseCmd),
        .forceMask(NMP_ZERO_BYTE),
        .value(wph)
    );

    nmp_fuse_byte #(.IMPL(NMP_IMPL_TRL)) u_trl (
        .core_clk(core_clk),
        .reset(reset),
        .clearEn(cfgWr && (idx == NMP_IDX_TABLE_READ_PROTECT_LOW)),
        .clearData(pwdata[7:0]),
        .eraseEn(eraseCmd),
        .forceMask(blk3Force),
        .value(trl)
    );

    // read mux; fuse values are already masked to implemented bits
    always_comb begin
        case (idx)
            NMP_IDX_CODE_PROTECT_HIGH: rdByte = cph;
            NMP_IDX_WRITE_PROTECT_LOW: rdByte = wpl;
            NMP_IDX_WRITE_PROTECT_HIGH: rdByte = wph;
            NMP_IDX_TABLE_READ_PROTECT_LOW: rdByte = trl;
            NMP_IDX_STATUS: rdByte = {6'h00, denied_reg, smallSync_reg};
            default: rdByte = NMP_ZERO_BYTE;
        endcase
    end

    // answer one cycle after setup: pready and data are both registered
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
            prdata <= (setup && !pwrite && mapped) ? {24'h000000, rdByte} : 32'h00000000;
        end
    end

    // classify the target and the code that issues the access
    nmp_region_decode u_tgt (
        .addr(reqAddr),
        .region(tgtRgn)
    );

    nmp_region_decode u_src (
        .addr(reqPcAddr),
        .region(srcRgn)
    );

    assign isWrite = (reqKind == KIND_WRITE) || (reqKind == KIND_EE_WRITE);

    // access decision; a guard bit at zero means protected
    always_comb begin
        allowNext = 1'b1;
        case (reqKind)
            KIND_TBLRD: begin
                // reads from inside the same block are always allowed
                if (tgtRgn != srcRgn) begin
                    case (tgtRgn)
                        RGN_BLK0: allowNext = trl[0];
                        RGN_BLK1: allowNext = trl[1];
                        RGN_BLK2: allowNext = trl[2];
                        RGN_BLK3: allowNext = trl[3];
                        default: allowNext = 1'b1;
                    endcase
                end
            end
            KIND_WRITE: begin
                case (tgtRgn)
                    RGN_BOOT: allowNext = wph[NMP_BIT_BOOT_WRITE];
                    RGN_BLK0: allowNext = wpl[0];
                    RGN_BLK1: allowNext = wpl[1];
                    RGN_BLK2: allowNext = wpl[2];
                    RGN_BLK3: allowNext = wpl[3];
                    RGN_CFG: allowNext = wph[NMP_BIT_CFG_WRITE];
                    default: allowNext = 1'b1;
                endcase
            end
            KIND_EE_WRITE: allowNext = wph[NMP_BIT_EEPROM_WRITE];
            KIND_EE_EXTREAD: allowNext = cph[NMP_BIT_EEPROM_CODE];
            KIND_EXT_READ: begin
                // only the boot block is code-guarded; other external reads are allowed
                allowNext = (tgtRgn != RGN_BOOT) || cph[NMP_BIT_BOOT_CODE];
            end
            default: allowNext = 1'b1;
        endcase
    end

    // registered answer, one cycle after the request
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rspValid <= 1'b0;
            rspAllow <= 1'b0;
            memWriteEn <= 1'b0;
        end else begin
            rspValid <= reqValid;
            rspAllow <= reqValid && allowNext;
            // a refused write never reaches the array, so nothing changes
            memWriteEn <= reqValid && allowNext && isWrite;
        end
    end

    // sticky refusal flag; a new refusal wins over a clear
    always_ff @(posedge core_clk) begin
        if (reset) begin
            denied_reg <= 1'b0;
        end else if (reqValid && !allowNext) begin
            denied_reg <= 1'b1;
        end else if (denyClear) begin
            denied_reg <= 1'b0;
        end
    end

    // code guard levels for the neighbouring read-out logic
    always_ff @(posedge core_clk) begin
        if (reset) begin
            eepromCodeGuarded <= 1'b0;
            bootCodeGuarded <= 1'b0;
        end else begin
            eepromCodeGuarded <= !cph[NMP_BIT_EEPROM_CODE];
            bootCodeGuarded <= !cph[NMP_BIT_BOOT_CODE];
        end
    end

    a_eeprom_code_deny:
    assert property (@(posedge core_clk) disable iff (reset)
        (reqValid && reqKind == KIND_EE_EXTREAD && !cph[7]) |=> (rspValid && !rspAllow))
    else $error("eeprom read allowed while code guarded");

    a_boot_code_deny:
    assert property (@(posedge core_clk) disable iff (reset)
        (reqValid && reqKind == KIND_EXT_READ && reqAddr <= 22'h0007FF)
        |=> (rspAllow == $past(cph[6])))
    else $error("boot outside read decision wrong");

    a_unimpl_reads_zero:
    assert property (@(posedge core_clk) disable iff (reset)
        (setup && !pwrite && idxOk && idx == NMP_IDX_WRITE_PROTECT_HIGH)
        |=> (pready && prdata[4:0] == 5'h00 && prdata[31:8] == 24'h000000))
    else $error("unimplemented bits read nonzero");

    a_blk3_write_guard:
    assert property (@(posedge core_clk) disable iff (reset)
        (reqValid && reqKind == KIND_WRITE && reqAddr[21:14] == 8'h03 && !wpl[3])
        |=> (!rspAllow && !memWriteEn))
    else $error("block 3 write passed while guarded");

    a_blk0_write_guard:
    assert property (@(posedge core_clk) disable iff (reset)
        (reqValid && reqKind == KIND_WRITE && reqAddr >= 22'h000800
        && reqAddr <= 22'h003FFF) |=> (memWriteEn == $past(wpl[0])))
    else $error("block 0 write decision wrong");

    a_blk1_write_guard:
    assert property (@(posedge core_clk) disable iff (reset)
        (reqValid && reqKind == KIND_WRITE && reqAddr >= 22'h004000
        && reqAddr <= 22'h007FFF) |=> (memWriteEn == $past(wpl[1])))
    else $error("block 1 write decision wrong");

    a_blk2_write_guard:
    assert property (@(posedge core_clk) disable iff (reset)
        (reqValid && reqKind == KIND_WRITE && reqAddr >= 22'h008000
        && reqAddr <= 22'h00BFFF) |=> (memWriteEn == $past(wpl[2])))
    else $error("block 2 write decision wrong");

    a_boot_write_guard:
    assert property (@(posedge core_clk) disable iff (reset)
        (reqValid && reqKind == KIND_WRITE && reqAddr <= 22'h0007FF)
        |=> (memWriteEn == $past(wph[6])))
    else $error("boot block write decision wrong");

    a_eeprom_write_guard:
    assert property (@(posedge core_clk) disable iff (reset)
        (reqValid && reqKind == KIND_EE_WRITE) |=> (memWriteEn == $past(wph[7])))
    else $error("eeprom write decision wrong");

    a_cfg_write_guard:
    assert property (@(posedge core_clk) disable iff (reset)
        (apbWr && !wph[5] && idx != NMP_IDX_ERASE_CTRL)
        |=> ({cph, wpl, wph, trl} == $past({cph, wpl, wph, trl})))
    else $error("fuse changed while config space guarded");

    a_blk3_read_guard:
    assert property (@(posedge core_clk) disable iff (reset)
        (reqValid && reqKind == KIND_TBLRD && reqAddr[21:14] == 8'h03)
        |=> (rspAllow == ($past(trl[3]) || $past(reqPcAddr[21:14]) == 8'h03)))
    else $error("block 3 table read decision wrong");

    a_blk2_read_guard:
    assert property (@(posedge core_clk) disable iff (reset)
        (reqValid && reqKind == KIND_TBLRD && reqAddr[21:14] == 8'h02 && !trl[2]
        && reqPcAddr[21:14] != 8'h02) |=> (rspValid && !rspAllow))
    else $error("block 2 table read passed while guarded");

    a_blk1_read_guard:
    assert property (@(posedge core_clk) disable iff (reset)
        (reqValid && reqKind == KIND_TBLRD && reqAddr[21:14] == 8'h01 && !trl[1]
        && reqPcAddr[21:14] != 8'h01) |=> (rspValid && !rspAllow))
    else $error("block 1 table read passed while guarded");

    a_blk0_read_guard:
    assert property (@(posedge core_clk) disable iff (reset)
        (reqValid && reqKind == KIND_TBLRD && reqAddr >= 22'h000800
        && reqAddr <= 22'h003FFF && !trl[0]
        && !(reqPcAddr >= 22'h000800 && reqPcAddr <= 22'h003FFF))
        |=> (rspValid && !rspAllow))
    else $error("block 0 table read passed while guarded");

    a_erase_restores:
    assert property (@(posedge core_clk) disable iff (reset)
        eraseCmd |=> (cph == NMP_IMPL_CPH && wpl == NMP_IMPL_WPL
        && wph == NMP_IMPL_WPH && trl == NMP_IMPL_TRL))
    else $error("erase did not restore fuses");

    a_no_set_by_write:
    assert property (@(posedge core_clk) disable iff (reset)
        !eraseCmd |=> ((wpl & ~$past(wpl) & ~blk3Force) == 8'h00))
    else $error("fuse bit returned to one without erase");

    a_denied_no_write:
    assert property (@(posedge core_clk) disable iff (reset)
        (rspValid && !rspAllow) |-> !memWriteEn)
    else $error("refused access still enabled a write");

    a_small_blk3_set:
    assert property (@(posedge core_clk) disable iff (reset)
        smallSync_reg |-> (wpl[3] && trl[3]))
    else $error("block 3 guards not held set on small part");

endmodule

/* nmp_host_model.sv */
// nmp_host_model: core table access logic and fuse programmer facing the block.
// assumes one core_clk; every signal changes by nba just after a rising edge.
`timescale 1ns/100ps
module nmp_host_model (
    input wire logic core_clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic reqValid,
    output nmp_pkg::nmp_kind_e reqKind,
    output logic [21:0] reqAddr,
    output logic [21:0] reqPcAddr,
    input wire logic rspValid,
    input wire logic rspAllow,
    input wire logic memWriteEn
);
    import nmp_pkg::*;

    // idle state at time zero, nothing requested
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        reqValid = 1'b0;
        reqKind = KIND_TBLRD;
        reqAddr = 22'h0;
        reqPcAddr = 22'h0;
    end

    // apb transfer; request held until pready is sampled high, only the bench timeout ends it
    task automatic apbXfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                           output logic [31:0] rdata, output logic err);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines flip so stale values never look valid
        paddr <= ~addr;
        pwdata <= ~wdata;
    endtask

    // one access check; answer sampled the cycle after the request edge
    task automatic coreReq(input nmp_kind_e kind, input logic [21:0] addr,
                           input logic [21:0] pc, output logic [2:0] rsp);
        @(posedge core_clk);
        reqValid <= 1'b1;
        reqKind <= kind;
        reqAddr <= addr;
        reqPcAddr <= pc;
        @(posedge core_clk);
        reqValid <= 1'b0;
        reqAddr <= ~addr;
        reqPcAddr <= ~pc;
        @(posedge core_clk);
        rsp = {rspValid, rspAllow, memWriteEn};
    endtask
endmodule

/* tb.sv */
// tb: self-checking bench of the memory protection fuse block.
// assumes nmp_host_model plays core and programmer; fuses start erased.
`timescale 1ns/100ps
module tb;
    import nmp_pkg::*;

    logic core_clk, reset, smallPart;
    logic psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata;
    logic reqValid, rspValid, rspAllow, memWriteEn, eepromCodeGuarded, bootCodeGuarded;
    nmp_kind_e reqKind;
    logic [21:0] reqAddr, reqPcAddr;
    int mismatches = 0;
    int samples_checked = 0;
    logic [21:0] blkAddr [4] = '{22'h000800, 22'h004000, 22'h008000, 22'h00FFFF};
    logic [21:0] hiAddr [3] = '{22'h000000, 22'h0007FF, 22'h300000};
    nmp_kind_e hiKind [3] = '{KIND_EE_WRITE, KIND_WRITE, KIND_WRITE};

    nmp_protect_top nmp_protect_top_i (.core_clk(core_clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .smallPart(smallPart), .reqValid(reqValid),
        .reqKind(reqKind), .reqAddr(reqAddr), .reqPcAddr(reqPcAddr), .rspValid(rspValid),
        .rspAllow(rspAllow), .memWriteEn(memWriteEn), .eepromCodeGuarded(eepromCodeGuarded),
        .bootCodeGuarded(bootCodeGuarded));
    nmp_host_model nmp_host_model_i (.core_clk(core_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .reqValid(reqValid), .reqKind(reqKind), .reqAddr(reqAddr),
        .reqPcAddr(reqPcAddr), .rspValid(rspValid), .rspAllow(rspAllow),
        .memWriteEn(memWriteEn));

    // 200 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    function automatic logic [31:0] regAddr(input logic [23:0] idx);
        return {NMP_ADDR_TOP_ZERO, idx, 2'b00};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rd(input logic [31:0] addr, input logic [31:0] exp, input logic errExp);
        logic [31:0] d;
        logic e;
        nmp_host_model_i.apbXfer(1'b0, addr, 32'h0, d, e);
        check(d, exp);
        check({31'h0, e}, {31'h0, errExp});
    endtask

    task automatic wr(input logic [23:0] idx, input logic [31:0] data);
        logic [31:0] d;
        logic e;
        nmp_host_model_i.apbXfer(1'b1, regAddr(idx), data, d, e);
        check({31'h0, e}, 32'h0);
    endtask

    task automatic req(input nmp_kind_e k, input logic [21:0] a, input logic [21:0] pc,
                       input logic [2:0] exp);
        logic [2:0] r;
        nmp_host_model_i.coreReq(k, a, pc, r);
        check({29'h0, r}, {29'h0, exp});
    endtask

    // full erase puts every fuse back to one, whatever the guards say
    task automatic erase();
        wr(NMP_IDX_ERASE_CTRL, 32'h0000_0001);
    endtask

    task automatic test_reset();
        rd(regAddr(NMP_IDX_CODE_PROTECT_HIGH), 32'h0000_00C0, 1'b0);
        rd(regAddr(NMP_IDX_WRITE_PROTECT_LOW), 32'h0000_000F, 1'b0);
        rd(regAddr(NMP_IDX_WRITE_PROTECT_HIGH), 32'h0000_00E0, 1'b0);
        rd(regAddr(NMP_IDX_TABLE_READ_PROTECT_LOW), 32'h0000_000F, 1'b0);
        rd(32'h00C0_0034, 32'h0, 1'b1);
        rd(32'h00C0_0025, 32'h0, 1'b1);
        $display("test_reset done");
    endtask

    task automatic test_wp_low();
        logic [7:0] m;
        for (int i = 0; i < 4; i++) begin
            m = 8'h01 << i;
            erase();
            req(KIND_WRITE, blkAddr[i], 22'h0, 3'b111);
            wr(NMP_IDX_WRITE_PROTECT_LOW, {24'h0, ~m});
            wr(NMP_IDX_WRITE_PROTECT_LOW, 32'h0000_00FF);
            rd(regAddr(NMP_IDX_WRITE_PROTECT_LOW), {24'h0, 8'h0F & ~m}, 1'b0);
            req(KIND_WRITE, blkAddr[i], 22'h0, 3'b100);
            req(KIND_WRITE, blkAddr[(i + 1) % 4], 22'h0, 3'b111);
        end
        $display("test_wp_low done");
    endtask

    task automatic test_wp_high();
        logic [7:0] m;
        for (int j = 0; j < 3; j++) begin
            m = 8'h80 >> j;
            erase();
            req(hiKind[j], hiAddr[j], 22'h0, 3'b111);
            wr(NMP_IDX_WRITE_PROTECT_HIGH, {24'h0, ~m});
            rd(regAddr(NMP_IDX_WRITE_PROTECT_HIGH), {24'h0, 8'hE0 & ~m}, 1'b0);
            req(hiKind[j], hiAddr[j], 22'h0, 3'b100);
        end
        // config space is now locked, so fuse writes must not land
        wr(NMP_IDX_CODE_PROTECT_HIGH, 32'h0);
        rd(regAddr(NMP_IDX_CODE_PROTECT_HIGH), 32'h0000_00C0, 1'b0);
        $display("test_wp_high done");
    endtask

    task automatic test_read_guard();
        logic [21:0] cur;
        logic [21:0] nxt;
        for (int i = 0; i < 4; i++) begin
            cur = blkAddr[i];
            nxt = blkAddr[(i + 1) % 4];
            erase();
            req(KIND_TBLRD, cur, nxt, 3'b110);
            wr(NMP_IDX_TABLE_READ_PROTECT_LOW, {24'h0, ~(8'h01 << i)});
            req(KIND_TBLRD, cur, cur, 3'b110);
            req(KIND_TBLRD, cur, nxt, 3'b100);
            req(KIND_TBLRD, cur, 22'h000000, 3'b100);
            req(KIND_TBLRD, nxt, cur, 3'b110);
        end
        $display("test_read_guard done");
    endtask

    task automatic test_code_guard();
        erase();
        repeat (2) @(posedge core_clk);
        check({30'h0, eepromCodeGuarded, bootCodeGuarded}, 32'h0);
        req(KIND_EE_EXTREAD, 22'h0, 22'h0, 3'b110);
        wr(NMP_IDX_CODE_PROTECT_HIGH, 32'h0000_007F);
        rd(regAddr(NMP_IDX_CODE_PROTECT_HIGH), 32'h0000_0040, 1'b0);
        check({30'h0, eepromCodeGuarded, bootCodeGuarded}, 32'h2);
        req(KIND_EE_EXTREAD, 22'h0, 22'h0, 3'b100);
        req(KIND_EXT_READ, 22'h000100, 22'h0, 3'b110);
        wr(NMP_IDX_CODE_PROTECT_HIGH, 32'h0000_00BF);
        repeat (2) @(posedge core_clk);
        check({30'h0, eepromCodeGuarded, bootCodeGuarded}, 32'h3);
        req(KIND_EXT_READ, 22'h0007FF, 22'h0, 3'b100);
        req(KIND_EXT_READ, 22'h000800, 22'h0, 3'b110);
        $display("test_code_guard done");
    endtask

    task automatic test_small();
        @(posedge core_clk);
        smallPart <= 1'b1;
        repeat (4) @(posedge core_clk);
        erase();
        // the programmer keeps the block 3 bits at one on the small part
        wr(NMP_IDX_WRITE_PROTECT_LOW, 32'h0000_0008);
        wr(NMP_IDX_TABLE_READ_PROTECT_LOW, 32'h0000_0008);
        rd(regAddr(NMP_IDX_WRITE_PROTECT_LOW), 32'h0000_0008, 1'b0);
        req(KIND_WRITE, 22'h00C000, 22'h0, 3'b111);
        req(KIND_TBLRD, 22'h00C000, 22'h000800, 3'b110);
        req(KIND_WRITE, 22'h008000, 22'h0, 3'b100);
        rd(regAddr(NMP_IDX_STATUS), 32'h0000_0003, 1'b0);
        wr(NMP_IDX_STATUS, 32'h0000_0002);
        rd(regAddr(NMP_IDX_STATUS), 32'h0000_0001, 1'b0);
        @(posedge core_clk);
        smallPart <= 1'b0;
        $display("test_small done");
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs a few hundred cycles
    initial begin
        #100000;
        mismatches++;
        finish_test();
    end

    // main sequence after two reset cycles
    initial begin
        reset = 1'b1;
        smallPart = 1'b0;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        test_reset();
        test_wp_low();
        test_wp_high();
        test_read_guard();
        test_code_guard();
        test_small();
        finish_test();
    end
endmodule
